// *** include/bcc_pkg.sv ***
// package of constants for the bcd clock and calendar block
package bcc_pkg;

  // ----------------------------------------------------------------
  // timing
  // ----------------------------------------------------------------
  localparam int CLK_PERIOD_NS = 8;
  localparam int HALF_SEC_NS = 500_000_000;
  localparam int HALF_SEC_CYC = HALF_SEC_NS / CLK_PERIOD_NS;
  localparam int SYNC_WIN_NS = 256;
  localparam int SYNC_WIN_CYC = (SYNC_WIN_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;

  // ----------------------------------------------------------------
  // register byte offsets
  // ----------------------------------------------------------------
  localparam logic [7:0] OFF_CTRL = 8'h00;
  localparam logic [7:0] OFF_CAL = 8'h04;
  localparam logic [7:0] OFF_ALM_CTRL = 8'h08;
  localparam logic [7:0] OFF_ALM_RPT = 8'h0C;
  localparam logic [7:0] OFF_YEAR = 8'h10;
  localparam logic [7:0] OFF_MONTH = 8'h14;
  localparam logic [7:0] OFF_DAY = 8'h18;
  localparam logic [7:0] OFF_WDAY = 8'h1C;
  localparam logic [7:0] OFF_HOUR = 8'h20;
  localparam logic [7:0] OFF_MIN = 8'h24;
  localparam logic [7:0] OFF_SEC = 8'h28;
  localparam logic [7:0] OFF_ALM_MONTH = 8'h2C;
  localparam logic [7:0] OFF_ALM_DATE = 8'h30;
  localparam logic [7:0] OFF_ALM_DOW = 8'h34;
  localparam logic [7:0] OFF_ALM_HOUR = 8'h38;
  localparam logic [7:0] OFF_ALM_MIN = 8'h3C;
  localparam logic [7:0] OFF_ALM_SEC = 8'h40;
  localparam logic [7:0] OFF_INT_STAT = 8'h44;
  localparam logic [7:0] OFF_INT_MASK = 8'h48;

  // ----------------------------------------------------------------
  // field positions
  // ----------------------------------------------------------------
  localparam int CTRL_EN_BIT = 7;
  localparam int CTRL_UNLOCK_BIT = 5;
  localparam int CTRL_SYNC_BIT = 4;
  localparam int CTRL_HALF_BIT = 3;
  localparam int ALM_EN_BIT = 7;
  localparam int INT_SEC_BIT = 0;
  localparam int INT_ALM_BIT = 1;

  // ----------------------------------------------------------------
  // reset values and limits, all bcd; then the bus response codes
  // ----------------------------------------------------------------
  localparam logic [7:0] RST_YEAR = 8'h00;
  localparam logic [7:0] RST_MONTH = 8'h01;
  localparam logic [7:0] RST_DAY = 8'h01;
  localparam logic [7:0] RST_ZERO = 8'h00;
  localparam logic [7:0] MAX_SEC = 8'h59;
  localparam logic [7:0] MAX_HOUR = 8'h23;
  localparam logic [7:0] MAX_WDAY = 8'h06;
  localparam logic [7:0] MAX_MONTH = 8'h12;
  localparam logic [7:0] MAX_YEAR = 8'h99;
  localparam logic [1:0] RESP_OKAY = 2'h0;
  localparam logic [1:0] RESP_SLVERR = 2'h2;

endpackage : bcc_pkg

// *** core/bcc_calendar_clock.sv ***
// bcd clock and calendar with an axi4-lite register slave
//
// Added by the designer: the register addresses and register access over AXI4-Lite.
`timescale 1ns/1ps

module bcc_calendar_clock
  import bcc_pkg::*;
#(
  parameter int HALF_SEC_CYCLES = HALF_SEC_CYC,
  parameter int SYNC_CYCLES = SYNC_WIN_CYC
) (
  input wire logic MCLK,
  input wire logic RST,
  input wire logic [7:0] AWADDR,
  input wire logic AWVALID,
  output logic AWREADY,
  input wire logic [31:0] WDATA,
  input wire logic [3:0] WSTRB,
  input wire logic WVALID,
  output logic WREADY,
  output logic [1:0] BRESP,
  output logic BVALID,
  input wire logic BREADY,
  input wire logic [7:0] ARADDR,
  input wire logic ARVALID,
  output logic ARREADY,
  output logic [31:0] RDATA,
  output logic [1:0] RRESP,
  output logic RVALID,
  input wire logic RREADY,
  output logic IRQ
);

  if (HALF_SEC_CYCLES < 2 * SYNC_CYCLES || SYNC_CYCLES < 1) begin : g_bad_param
    $error("half-second count must be at least twice the sync window");
  end

  // ----------------------------------------------------------------
  // helpers
  // ----------------------------------------------------------------
  function automatic logic [7:0] bcd_inc(input logic [7:0] v, input logic [7:0] lim,
                                         input logic [7:0] base);
    if (v == lim) begin
      return base;
    end else if (v[3:0] == 4'h9) begin
      return {v[7:4] + 4'h1, 4'h0};
    end else begin
      return {v[7:4], v[3:0] + 4'h1};
    end
  endfunction : bcd_inc

  // year in 2000..2099: divisible by four in bcd terms
  function automatic logic is_leap(input logic [7:0] y);
    if (y[4] == 1'b0) begin
      return (y[3:0] == 4'h0) || (y[3:0] == 4'h4) || (y[3:0] == 4'h8);
    end else begin
      return (y[3:0] == 4'h2) || (y[3:0] == 4'h6);
    end
  endfunction : is_leap

  function automatic logic [7:0] month_len(input logic [7:0] m, input logic [7:0] y);
    unique case (m)
      8'h02: month_len = is_leap(y) ? 8'h29 : 8'h28;
      8'h04, 8'h06, 8'h09, 8'h11: month_len = 8'h30;
      default: month_len = 8'h31;
    endcase
  endfunction : month_len

  // ----------------------------------------------------------------
  // axi4-lite write channel
  // ----------------------------------------------------------------
  logic awready_ff, wready_ff, bvalid_ff, aw_got_ff, w_got_ff;
  logic [1:0] bresp_ff;
  logic [7:0] waddr_ff;
  logic [31:0] wdata_ff;
  logic [3:0] wstrb_ff;
  logic do_wr;
  logic wr_known;

  assign do_wr = aw_got_ff && w_got_ff && !bvalid_ff;

  always_ff @(posedge MCLK) begin
    if (RST) begin
      awready_ff <= 1'b1;
      aw_got_ff <= 1'b0;
      waddr_ff <= 8'h00;
    end else if (AWVALID && awready_ff) begin
      awready_ff <= 1'b0;
      aw_got_ff <= 1'b1;
      waddr_ff <= AWADDR;
    end else if (do_wr) begin
      aw_got_ff <= 1'b0;
    end else if (bvalid_ff && BREADY) begin
      awready_ff <= 1'b1;
    end
  end

  always_ff @(posedge MCLK) begin
    if (RST) begin
      wready_ff <= 1'b1;
      w_got_ff <= 1'b0;
      wdata_ff <= 32'h0000_0000;
      wstrb_ff <= 4'h0;
    end else if (WVALID && wready_ff) begin
      wready_ff <= 1'b0;
      w_got_ff <= 1'b1;
      wdata_ff <= WDATA;
      wstrb_ff <= WSTRB;
    end else if (do_wr) begin
      w_got_ff <= 1'b0;
    end else if (bvalid_ff && BREADY) begin
      wready_ff <= 1'b1;
    end
  end

  assign wr_known = (waddr_ff[1:0] == 2'b00) && (waddr_ff <= OFF_INT_MASK);

  always_ff @(posedge MCLK) begin
    if (RST) begin
      bvalid_ff <= 1'b0;
      bresp_ff <= RESP_OKAY;
    end else if (do_wr) begin
      bvalid_ff <= 1'b1;
      bresp_ff <= wr_known ? RESP_OKAY : RESP_SLVERR;
    end else if (BREADY) begin
      bvalid_ff <= 1'b0;
    end
  end

  // only byte lane 0 carries register data; other lanes are ignored
  function automatic logic hit(input logic [7:0] off);
    return do_wr && (waddr_ff == off) && wstrb_ff[0];
  endfunction : hit

  // ----------------------------------------------------------------
  // control and prescaler
  // ----------------------------------------------------------------
  logic en_ff, unlock_ff, half_ff, sync_flag;
  logic [31:0] presc_ff;
  logic half_tick, sec_tick, sec_wr;
  logic [7:0] wd;

  assign wd = wdata_ff[7:0];

  always_ff @(posedge MCLK) begin
    if (RST) begin
      unlock_ff <= 1'b0;
    end else if (hit(OFF_CTRL)) begin
      unlock_ff <= wd[CTRL_UNLOCK_BIT];
    end
  end

  always_ff @(posedge MCLK) begin
    if (RST) begin
      en_ff <= 1'b0;
    end else if (hit(OFF_CTRL) && unlock_ff) begin
      en_ff <= wd[CTRL_EN_BIT];
    end
  end

  // the lock gates the seconds write before it may touch the prescaler;
  // a process rather than an assign, so the state read inside hit() wakes it
  always_comb begin
    sec_wr = hit(OFF_SEC) && unlock_ff;
  end
  assign half_tick = en_ff && (presc_ff == 32'(HALF_SEC_CYCLES - 1));
  assign sec_tick = half_tick && half_ff;

  always_ff @(posedge MCLK) begin
    if (RST) begin
      presc_ff <= 32'h0000_0000;
    end else if (sec_wr || half_tick) begin
      presc_ff <= 32'h0000_0000;
    end else if (en_ff) begin
      presc_ff <= presc_ff + 32'h0000_0001;
    end
  end

  always_ff @(posedge MCLK) begin
    if (RST) begin
      half_ff <= 1'b0;
    end else if (sec_wr) begin
      half_ff <= 1'b0;
    end else if (half_tick) begin
      half_ff <= !half_ff;
    end
  end

  // warns software that a seconds carry is a few cycles away
  assign sync_flag = en_ff && half_ff &&
                     (presc_ff >= 32'(HALF_SEC_CYCLES - SYNC_CYCLES));

  // ----------------------------------------------------------------
  // time cascade
  // ----------------------------------------------------------------
  logic [7:0] sec_ff, min_ff, hour_ff, wday_ff, day_ff, month_ff, year_ff;
  logic c_min, c_hour, c_day, c_month, c_year;

  assign c_min = sec_tick && (sec_ff == MAX_SEC);
  assign c_hour = c_min && (min_ff == MAX_SEC);
  assign c_day = c_hour && (hour_ff == MAX_HOUR);
  assign c_month = c_day && (day_ff == month_len(month_ff, year_ff));
  assign c_year = c_month && (month_ff == MAX_MONTH);

  // a write in the tick cycle wins for its own field; others keep counting
  always_ff @(posedge MCLK) begin
    if (RST) begin
      sec_ff <= RST_ZERO;
    end else if (sec_wr) begin
      sec_ff <= wd;
    end else if (sec_tick) begin
      sec_ff <= bcd_inc(sec_ff, MAX_SEC, RST_ZERO);
    end
  end

  always_ff @(posedge MCLK) begin
    if (RST) begin
      min_ff <= RST_ZERO;
    end else if (hit(OFF_MIN) && unlock_ff) begin
      min_ff <= wd;
    end else if (c_min) begin
      min_ff <= bcd_inc(min_ff, MAX_SEC, RST_ZERO);
    end
  end

  always_ff @(posedge MCLK) begin
    if (RST) begin
      hour_ff <= RST_ZERO;
    end else if (hit(OFF_HOUR) && unlock_ff) begin
      hour_ff <= wd;
    end else if (c_hour) begin
      hour_ff <= bcd_inc(hour_ff, MAX_HOUR, RST_ZERO);
    end
  end

  // weekday only follows the day carry from whatever software loaded
  always_ff @(posedge MCLK) begin
    if (RST) begin
      wday_ff <= RST_ZERO;
    end else if (hit(OFF_WDAY) && unlock_ff) begin
      wday_ff <= wd;
    end else if (c_day) begin
      wday_ff <= bcd_inc(wday_ff, MAX_WDAY, RST_ZERO);
    end
  end

  always_ff @(posedge MCLK) begin
    if (RST) begin
      day_ff <= RST_DAY;
    end else if (hit(OFF_DAY) && unlock_ff) begin
      day_ff <= wd;
    end else if (c_day) begin
      day_ff <= bcd_inc(day_ff, month_len(month_ff, year_ff), RST_DAY);
    end
  end

  always_ff @(posedge MCLK) begin
    if (RST) begin
      month_ff <= RST_MONTH;
    end else if (hit(OFF_MONTH) && unlock_ff) begin
      month_ff <= wd;
    end else if (c_month) begin
      month_ff <= bcd_inc(month_ff, MAX_MONTH, RST_MONTH);
    end
  end

  // 99 wraps to 00: end of 2099 returns to the start of 2000
  always_ff @(posedge MCLK) begin
    if (RST) begin
      year_ff <= RST_YEAR;
    end else if (hit(OFF_YEAR) && unlock_ff) begin
      year_ff <= wd;
    end else if (c_year) begin
      year_ff <= bcd_inc(year_ff, MAX_YEAR, RST_YEAR);
    end
  end

  // ----------------------------------------------------------------
  // calibration and alarm registers
  // ----------------------------------------------------------------
  logic [7:0] cal_ff, alm_ctrl_ff, alm_rpt_ff;
  logic [7:0] a_mon_ff, a_date_ff, a_dow_ff, a_hour_ff, a_min_ff, a_sec_ff;
  logic tick_d_ff, alm_match, alm_evt;

  always_ff @(posedge MCLK) begin
    if (RST) begin
      cal_ff <= RST_ZERO;
      a_mon_ff <= RST_ZERO;
      a_date_ff <= RST_ZERO;
      a_dow_ff <= RST_ZERO;
      a_hour_ff <= RST_ZERO;
      a_min_ff <= RST_ZERO;
      a_sec_ff <= RST_ZERO;
    end else begin
      if (hit(OFF_CAL)) cal_ff <= wd;
      if (hit(OFF_ALM_MONTH)) a_mon_ff <= wd;
      if (hit(OFF_ALM_DATE)) a_date_ff <= wd;
      if (hit(OFF_ALM_DOW)) a_dow_ff <= wd;
      if (hit(OFF_ALM_HOUR)) a_hour_ff <= wd;
      if (hit(OFF_ALM_MIN)) a_min_ff <= wd;
      if (hit(OFF_ALM_SEC)) a_sec_ff <= wd;
    end
  end

  // compare the clock one cycle after each second step, once per second
  always_ff @(posedge MCLK) begin
    if (RST) begin
      tick_d_ff <= 1'b0;
    end else begin
      tick_d_ff <= sec_tick;
    end
  end

  // bits 5..0 of alarm control pick month, date, weekday, hour, minute, second
  assign alm_match = (!alm_ctrl_ff[5] || (a_mon_ff == month_ff)) &&
                     (!alm_ctrl_ff[4] || (a_date_ff == day_ff)) &&
                     (!alm_ctrl_ff[3] || (a_dow_ff == wday_ff)) &&
                     (!alm_ctrl_ff[2] || (a_hour_ff == hour_ff)) &&
                     (!alm_ctrl_ff[1] || (a_min_ff == min_ff)) &&
                     (!alm_ctrl_ff[0] || (a_sec_ff == sec_ff));
  assign alm_evt = tick_d_ff && alm_ctrl_ff[ALM_EN_BIT] && alm_match;

  // the repeat count runs down per alarm; at zero the alarm disarms itself
  always_ff @(posedge MCLK) begin
    if (RST) begin
      alm_ctrl_ff <= RST_ZERO;
    end else if (hit(OFF_ALM_CTRL)) begin
      alm_ctrl_ff <= wd;
    end else if (alm_evt && (alm_rpt_ff == RST_ZERO)) begin
      alm_ctrl_ff[ALM_EN_BIT] <= 1'b0;
    end
  end

  always_ff @(posedge MCLK) begin
    if (RST) begin
      alm_rpt_ff <= RST_ZERO;
    end else if (hit(OFF_ALM_RPT)) begin
      alm_rpt_ff <= wd;
    end else if (alm_evt && (alm_rpt_ff != RST_ZERO)) begin
      alm_rpt_ff <= alm_rpt_ff - 8'h01;
    end
  end

  // ----------------------------------------------------------------
  // interrupt status and mask
  // ----------------------------------------------------------------
  logic [1:0] stat_ff, mask_ff, clr, evt;
  logic irq_ff;

  assign evt = {alm_evt, sec_tick};
  always_comb begin
    clr = hit(OFF_INT_STAT) ? wd[1:0] : 2'h0;
  end

  // a new event in the clearing cycle survives the clear
  always_ff @(posedge MCLK) begin
    if (RST) begin
      stat_ff <= 2'h0;
    end else begin
      stat_ff <= (stat_ff & ~clr) | evt;
    end
  end

  always_ff @(posedge MCLK) begin
    if (RST) begin
      mask_ff <= 2'h0;
    end else if (hit(OFF_INT_MASK)) begin
      mask_ff <= wd[1:0];
    end
  end

  always_ff @(posedge MCLK) begin
    if (RST) begin
      irq_ff <= 1'b0;
    end else begin
      irq_ff <= |(stat_ff & mask_ff);
    end
  end

  // ----------------------------------------------------------------
  // axi4-lite read channel
  // ----------------------------------------------------------------
  logic arready_ff, rvalid_ff;
  logic [1:0] rresp_ff;
  logic [31:0] rdata_ff;
  logic [7:0] rd_val;
  logic rd_ok;

  always_comb begin
    rd_ok = 1'b1;
    unique case (ARADDR)
      OFF_CTRL: rd_val = {en_ff, 1'b0, unlock_ff, sync_flag, half_ff, 3'h0};
      OFF_CAL: rd_val = cal_ff;
      OFF_ALM_CTRL: rd_val = alm_ctrl_ff;
      OFF_ALM_RPT: rd_val = alm_rpt_ff;
      OFF_YEAR: rd_val = year_ff;
      OFF_MONTH: rd_val = month_ff;
      OFF_DAY: rd_val = day_ff;
      OFF_WDAY: rd_val = wday_ff;
      OFF_HOUR: rd_val = hour_ff;
      OFF_MIN: rd_val = min_ff;
      OFF_SEC: rd_val = sec_ff;
      OFF_ALM_MONTH: rd_val = a_mon_ff;
      OFF_ALM_DATE: rd_val = a_date_ff;
      OFF_ALM_DOW: rd_val = a_dow_ff;
      OFF_ALM_HOUR: rd_val = a_hour_ff;
      OFF_ALM_MIN: rd_val = a_min_ff;
      OFF_ALM_SEC: rd_val = a_sec_ff;
      OFF_INT_STAT: rd_val = {6'h00, stat_ff};
      OFF_INT_MASK: rd_val = {6'h00, mask_ff};
      default: begin
        rd_val = 8'h00;
        rd_ok = 1'b0;
      end
    endcase
  end

  always_ff @(posedge MCLK) begin
    if (RST) begin
      arready_ff <= 1'b1;
      rvalid_ff <= 1'b0;
      rdata_ff <= 32'h0000_0000;
      rresp_ff <= RESP_OKAY;
    end else if (ARVALID && arready_ff) begin
      arready_ff <= 1'b0;
      rvalid_ff <= 1'b1;
      rdata_ff <= {24'h00_0000, rd_val};
      rresp_ff <= rd_ok ? RESP_OKAY : RESP_SLVERR;
    end else if (rvalid_ff && RREADY) begin
      arready_ff <= 1'b1;
      rvalid_ff <= 1'b0;
    end
  end

  assign AWREADY = awready_ff;
  assign WREADY = wready_ff;
  assign BVALID = bvalid_ff;
  assign BRESP = bresp_ff;
  assign ARREADY = arready_ff;
  assign RVALID = rvalid_ff;
  assign RDATA = rdata_ff;
  assign RRESP = rresp_ff;
  assign IRQ = irq_ff;

endmodule : bcc_calendar_clock

// *** verif/bcc_calendar_clock_assertions.sv ***
// concurrent checks on the register bus and the bcd time fields
`timescale 1ns/1ps
module bcc_calendar_clock_assertions
  import bcc_pkg::*;
#(
  parameter int HALF_SEC_CYCLES = HALF_SEC_CYC,
  parameter int SYNC_CYCLES = SYNC_WIN_CYC
) (
  input wire logic MCLK,
  input wire logic RST,
  input wire logic AWVALID,
  input wire logic AWREADY,
  input wire logic WVALID,
  input wire logic WREADY,
  input wire logic BVALID,
  input wire logic BREADY,
  input wire logic [7:0] ARADDR,
  input wire logic ARVALID,
  input wire logic ARREADY,
  input wire logic [31:0] RDATA,
  input wire logic RVALID,
  input wire logic RREADY
);
  // ----------------------------------------------------------------
  // read address tracker
  // ----------------------------------------------------------------
  // remembers which register the pending read data belongs to
  logic [7:0] rd_addr_ff;
  logic [7:0] rd_byte;
  assign rd_byte = RDATA[7:0];
  always_ff @(posedge MCLK) begin
    if (ARVALID && ARREADY) begin
      rd_addr_ff <= ARADDR;
    end
  end
  default clocking cb @(posedge MCLK); endclocking
  default disable iff (RST);
  // ----------------------------------------------------------------
  // properties
  // ----------------------------------------------------------------
  sequence s_wr_taken;
    AWVALID && AWREADY && WVALID && WREADY;
  endsequence
  sequence s_wr_answer;
    ##[1:2] BVALID;
  endsequence
  property p_wr_answer;
    s_wr_taken |-> s_wr_answer;
  endproperty
  property p_rd_answer;
    ARVALID && ARREADY |=> RVALID;
  endproperty
  property p_rd_hold;
    RVALID && !RREADY |=> RVALID && $stable(RDATA);
  endproperty
  property p_bcd_digits;
    RVALID && rd_addr_ff >= OFF_YEAR && rd_addr_ff <= OFF_ALM_SEC
      |-> RDATA[31:8] == 24'h0 && rd_byte[7:4] <= 4'h9 && rd_byte[3:0] <= 4'h9;
  endproperty
  property p_hour_range;
    RVALID && rd_addr_ff == OFF_HOUR |-> rd_byte <= MAX_HOUR;
  endproperty
  property p_minsec_range;
    RVALID && (rd_addr_ff == OFF_MIN || rd_addr_ff == OFF_SEC) |-> rd_byte <= MAX_SEC;
  endproperty
  property p_month_range;
    RVALID && rd_addr_ff == OFF_MONTH |-> rd_byte != 8'h00 && rd_byte <= MAX_MONTH;
  endproperty
  property p_day_range;
    RVALID && rd_addr_ff == OFF_DAY |-> rd_byte != 8'h00 && rd_byte <= 8'h31;
  endproperty
  a_wr_answer: assert property (p_wr_answer)
    else $error("write answer late");
  a_rd_answer: assert property (p_rd_answer)
    else $error("read answer late");
  a_rd_hold: assert property (p_rd_hold)
    else $error("read data dropped before taken");
  a_bcd_digits: assert property (p_bcd_digits)
    else $error("value register not bcd");
  a_hour_range: assert property (p_hour_range)
    else $error("hour above 23");
  a_minsec_range: assert property (p_minsec_range)
    else $error("minute or second above 59");
  a_month_range: assert property (p_month_range)
    else $error("month out of range");
  a_day_range: assert property (p_day_range)
    else $error("day out of range");
endmodule : bcc_calendar_clock_assertions

bind bcc_calendar_clock bcc_calendar_clock_assertions #(
  .HALF_SEC_CYCLES(HALF_SEC_CYCLES),
  .SYNC_CYCLES(SYNC_CYCLES)
) u_chk (
  .MCLK, .RST, .AWVALID, .AWREADY, .WVALID, .WREADY, .BVALID, .BREADY,
  .ARADDR, .ARVALID, .ARREADY, .RDATA, .RVALID, .RREADY
);

// *** verif/tb_top.sv ***
// register-level testbench for the bcd clock and calendar
`timescale 1ns/1ps
`define CHK(nm, ex, got) begin tests_run++; if ((got) !== (ex)) begin fails++; \
  $display("unexpected %s expected %h seen %h", nm, ex, got); end end
module tb_top
  import bcc_pkg::*;
;
  logic MCLK, RST, AWVALID, WVALID, BREADY, ARVALID, RREADY;
  logic AWREADY, WREADY, BVALID, ARREADY, RVALID, IRQ;
  logic [7:0] AWADDR, ARADDR, rdv;
  logic [31:0] WDATA, RDATA;
  logic [3:0] WSTRB;
  logic [1:0] BRESP, RRESP, wrsp;
  int fails = 0;
  int tests_run = 0;
  int cyc = 0;
  int t0;
  int n;
  logic [7:0] tm_a [7] = '{OFF_YEAR, OFF_MONTH, OFF_DAY, OFF_WDAY, OFF_HOUR, OFF_MIN, OFF_SEC};
  logic [7:0] tm_z [7] = '{RST_YEAR, RST_MONTH, RST_DAY, RST_ZERO, RST_ZERO, RST_ZERO, RST_ZERO};
  logic [7:0] tm_s [7] = '{8'h99, 8'h12, 8'h31, 8'h06, 8'h23, 8'h59, 8'h58};
  // year, month, day, then the month and day expected one second later
  logic [7:0] lp [6][5] = '{'{8'h24, 8'h02, 8'h28, 8'h02, 8'h29},
    '{8'h23, 8'h02, 8'h28, 8'h03, 8'h01}, '{8'h24, 8'h02, 8'h29, 8'h03, 8'h01},
    '{8'h00, 8'h02, 8'h28, 8'h02, 8'h29}, '{8'h21, 8'h04, 8'h30, 8'h05, 8'h01},
    '{8'h21, 8'h01, 8'h31, 8'h02, 8'h01}};

  // short half-second count keeps one second at sixteen cycles
  bcc_calendar_clock #(.HALF_SEC_CYCLES(8), .SYNC_CYCLES(2)) dut (
    .MCLK, .RST, .AWADDR, .AWVALID, .AWREADY, .WDATA, .WSTRB, .WVALID, .WREADY,
    .BRESP, .BVALID, .BREADY, .ARADDR, .ARVALID, .ARREADY, .RDATA, .RRESP, .RVALID,
    .RREADY, .IRQ
  );

  initial begin
    MCLK = 1'b0;
    forever #4 MCLK = ~MCLK;
  end
  always @(posedge MCLK) cyc <= cyc + 1;

  // ----------------------------------------------------------------
  // bus tasks
  // ----------------------------------------------------------------
  task automatic finish_test();
    $display("comparisons %0d mismatches %0d", tests_run, fails);
    if (fails == 0 && tests_run > 0) begin
      $display("verification passed");
    end else begin
      $display("verification failed");
    end
    $finish;
  endtask : finish_test

  task automatic timed_out();
    fails++;
    $display("unexpected bus answer expected %h seen %h", 1'b1, 1'b0);
    finish_test();
  endtask : timed_out

  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    AWADDR <= a;
    WDATA <= {24'h0, d};
    WSTRB <= 4'hF;
    AWVALID <= 1'b1;
    WVALID <= 1'b1;
    for (n = 0; n < 40; n++) begin
      @(posedge MCLK);
      if (AWREADY && AWVALID) AWVALID <= 1'b0;
      if (WREADY && WVALID) WVALID <= 1'b0;
      wrsp = BRESP;
      if (BVALID) break;
    end
    if (n == 40) timed_out();
  endtask : wr

  task automatic rd(input logic [7:0] a);
    ARADDR <= a;
    ARVALID <= 1'b1;
    for (n = 0; n < 40; n++) begin
      @(posedge MCLK);
      if (ARREADY && ARVALID) ARVALID <= 1'b0;
      if (RVALID) break;
    end
    rdv = RDATA[7:0];
    if (n == 40) timed_out();
  endtask : rd

  task automatic rchk(input logic [7:0] a, input logic [7:0] ex, input string nm);
    rd(a);
    `CHK(nm, ex, rdv)
  endtask : rchk

  task automatic till(input int t);
    while (cyc < t) @(posedge MCLK);
  endtask : till

  // ----------------------------------------------------------------
  // main sequence
  // ----------------------------------------------------------------
  initial begin
    RST = 1'b1;
    {AWADDR, ARADDR, WDATA, WSTRB} = '0;
    {AWVALID, WVALID, ARVALID} = '0;
    // both answer readies stay high, so back-to-back calls never toggle them
    {BREADY, RREADY} = 2'b11;
    repeat (4) @(posedge MCLK);
    RST <= 1'b0;
    @(posedge MCLK);
    for (int i = 0; i < 7; i++) rchk(tm_a[i], tm_z[i], "reset time");
    rchk(OFF_CTRL, 8'h00, "reset control");
    rd(8'h4C);
    `CHK("unmapped response", RESP_SLVERR, RRESP)
    wr(8'h4C, 8'h00);
    `CHK("unmapped write response", RESP_SLVERR, wrsp)
    wr(OFF_HOUR, 8'h12);
    `CHK("locked write response", RESP_OKAY, wrsp)
    rchk(OFF_HOUR, 8'h00, "locked hour");
    wr(OFF_CTRL, 8'h80);
    rchk(OFF_CTRL, 8'h00, "locked enable");
    // load two seconds before the end of the range with the clock stopped
    wr(OFF_CTRL, 8'h20);
    for (int i = 0; i < 7; i++) wr(tm_a[i], tm_s[i]);
    rchk(OFF_HOUR, 8'h23, "loaded hour");
    wr(OFF_CTRL, 8'hA0);
    till(cyc + 14);
    wr(OFF_SEC, 8'h58);
    t0 = cyc;
    rd(OFF_CTRL);
    `CHK("half cleared", 1'b0, rdv[CTRL_HALF_BIT])
    rchk(OFF_SEC, 8'h58, "written second");
    till(t0 + 10);
    rd(OFF_CTRL);
    `CHK("half set", 1'b1, rdv[CTRL_HALF_BIT])
    `CHK("sync early", 1'b0, rdv[CTRL_SYNC_BIT])
    // this read lands two counts before the seconds carry
    till(t0 + 13);
    rd(OFF_CTRL);
    `CHK("sync window", 1'b1, rdv[CTRL_SYNC_BIT])
    till(t0 + 20);
    rchk(OFF_SEC, 8'h59, "one step");
    till(t0 + 38);
    wr(OFF_CTRL, 8'h20);
    for (int i = 0; i < 7; i++) rchk(tm_a[i], tm_z[i], "range wrap");
    till(cyc + 40);
    rchk(OFF_SEC, 8'h00, "stopped");
    for (int i = 0; i < 6; i++) begin
      wr(OFF_YEAR, lp[i][0]);
      wr(OFF_MONTH, lp[i][1]);
      wr(OFF_DAY, lp[i][2]);
      wr(OFF_HOUR, 8'h23);
      wr(OFF_MIN, 8'h59);
      wr(OFF_SEC, 8'h59);
      wr(OFF_CTRL, 8'hA0);
      t0 = cyc;
      till(t0 + 22);
      wr(OFF_CTRL, 8'h20);
      rchk(OFF_MONTH, lp[i][3], "month carry");
      rchk(OFF_DAY, lp[i][4], "day carry");
      rchk(OFF_HOUR, 8'h00, "hour wrap");
    end
    // alarm on a seconds match, only the alarm event unmasked
    wr(OFF_INT_MASK, 8'h02);
    wr(OFF_ALM_SEC, 8'h05);
    wr(OFF_ALM_RPT, 8'h00);
    wr(OFF_ALM_CTRL, 8'h81);
    wr(OFF_SEC, 8'h03);
    wr(OFF_CTRL, 8'hA0);
    t0 = cyc;
    till(t0 + 20);
    `CHK("masked second irq", 1'b0, IRQ)
    for (n = 0; n < 40 && IRQ !== 1'b1; n++) @(posedge MCLK);
    `CHK("alarm irq", 1'b1, IRQ)
    rchk(OFF_INT_STAT, 8'h03, "event status");
    rchk(OFF_ALM_CTRL, 8'h01, "alarm disarmed");
    wr(OFF_INT_STAT, 8'h02);
    @(posedge MCLK);
    `CHK("alarm cleared", 1'b0, IRQ)
    wr(OFF_INT_MASK, 8'h01);
    repeat (2) @(posedge MCLK);
    `CHK("second irq", 1'b1, IRQ)
    wr(OFF_CTRL, 8'h00);
    wr(OFF_INT_STAT, 8'h03);
    finish_test();
  end
endmodule : tb_top
